// ==== src/fsg_pkg.sv ====
// Functional notes
// RULE_01 - start: current low, then above start level
// RULE_02 - started motor stops below ten percent
// RULE_03 - alarm at second last permitted start
// RULE_04 - alarm holds until limit or hour ends
// RULE_05 - inhibit on each start for interval
// RULE_06 - inhibit releases when interval expires
// RULE_07 - limit reached inhibits until hour passes
// RULE_08 - force flag clears five minutes after button
// RULE_09 - expose hourly starts and minutes since start
// RULE_10 - max starts per hour setting is limit
// RULE_11 - min interval setting in minutes
// RULE_12 - record trip time, rates and total starts
// RULE_13 - alarm and inhibit mapped to contacts
// RULE_14 - enableable events on alarm and inhibit edges
package fsg_pkg;

   // ------------------------------------------------------------
   // time base
   // ------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam int unsigned SECOND_NS = 1_000_000_000;
   localparam int unsigned CYCLES_PER_SECOND = SECOND_NS / CLK_PERIOD_NS;
   localparam int unsigned SECONDS_PER_MINUTE = 60;
   localparam int unsigned MINUTES_PER_HOUR = 60;
   localparam int unsigned HOUR_S = MINUTES_PER_HOUR * SECONDS_PER_MINUTE;
   localparam int unsigned FORCE_TIMEOUT_MIN = 5;
   localparam int unsigned FORCE_TIMEOUT_S =
      FORCE_TIMEOUT_MIN * SECONDS_PER_MINUTE;

   // ------------------------------------------------------------
   // widths and levels
   // ------------------------------------------------------------
   localparam int unsigned CUR_W = 16;
   localparam int unsigned CNT_W = 8;
   localparam int unsigned MIN_W = 16;
   localparam int unsigned TOT_W = 16;
   localparam int unsigned TS_W = 32;
   localparam int unsigned STAMP_W = 12;
   localparam int unsigned HIST_DEPTH = 32;
   localparam int unsigned HIST_PTR_W = 5;
   localparam int unsigned IVL_W = 14;
   localparam int unsigned FRC_W = 9;
   localparam int unsigned SEC_W = 6;
   localparam int unsigned N_CONTACTS = 4;
   localparam int unsigned PROD_W = 24;
   localparam logic [7:0] STOP_LEVEL_PCT = 8'h0a;
   localparam logic [7:0] PCT_SCALE = 8'h64;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      MOT_UNKNOWN = 2'b00,
      MOT_STOPPED = 2'b01,
      MOT_STARTED = 2'b10
   } motor_state_e;

   typedef struct packed {
      logic alarm;
      logic inhibit;
   } guard_out_s;

   typedef struct packed {
      logic alarm_on;
      logic alarm_off;
      logic inhibit_on;
      logic inhibit_off;
   } event_s;

   typedef struct packed {
      logic [N_CONTACTS-1:0] alarm_sel;
      logic [N_CONTACTS-1:0] inhibit_sel;
      logic [N_CONTACTS-1:0] invert;
   } contact_map_s;

   typedef struct packed {
      logic [TS_W-1:0] trip_timestamp;
      logic [CNT_W-1:0] recorded_starts_per_hour;
      logic [MIN_W-1:0] recorded_time_since_start;
      logic [TOT_W-1:0] total_starts;
   } record_s;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam guard_out_s GUARD_RESET = 2'h0;
   localparam event_s EVENT_RESET = 4'h0;
   localparam record_s RECORD_RESET = 72'h0;
   localparam logic FORCE_RESET = 1'b0;

   // true when cur is below pct percent of nom
   function automatic logic below_pct(input logic [CUR_W-1:0] cur,
                                      input logic [CUR_W-1:0] nom,
                                      input logic [7:0] pct);
      logic [PROD_W-1:0] lhs;
      logic [PROD_W-1:0] rhs;
      lhs = PROD_W'(cur) * PROD_W'(PCT_SCALE);
      rhs = PROD_W'(nom) * PROD_W'(pct);
      return lhs < rhs;
   endfunction

endpackage

// ==== src/motor_frequent_start_guard.sv ====
`timescale 1ns/10ps
`default_nettype none
module motor_frequent_start_guard #(
   parameter int unsigned CYCLES_PER_SECOND = fsg_pkg::CYCLES_PER_SECOND
) (
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic enable_i,
   input wire logic [fsg_pkg::CUR_W-1:0] current_i,
   input wire logic [fsg_pkg::CUR_W-1:0] nominal_current_i,
   input wire logic [fsg_pkg::CUR_W-1:0] start_current_i,
   input wire logic [fsg_pkg::CNT_W-1:0] max_starts_i,
   input wire logic [fsg_pkg::CNT_W-1:0] min_interval_i,
   input wire logic button_press_i,
   input wire logic force_set_i,
   input wire logic force_clear_i,
   input wire fsg_pkg::guard_out_s forced_out_i,
   input wire fsg_pkg::event_s event_enable_i,
   input wire fsg_pkg::contact_map_s contact_map_i,
   input wire logic [fsg_pkg::TS_W-1:0] rtc_time_i,
   output fsg_pkg::guard_out_s guard_o,
   output logic [fsg_pkg::N_CONTACTS-1:0] contacts_o,
   output fsg_pkg::event_s events_o,
   output logic [fsg_pkg::CNT_W-1:0] starts_last_hour_o,
   output logic [fsg_pkg::MIN_W-1:0] minutes_since_start_o,
   output logic [fsg_pkg::TOT_W-1:0] start_event_count_o,
   output fsg_pkg::record_s record_o,
   output logic force_o,
   output logic motor_started_o
);

   // ------------------------------------------------------------
   // constants at the width of what they meet
   // ------------------------------------------------------------
   localparam logic [fsg_pkg::SEC_W-1:0] LAST_SEC =
      fsg_pkg::SEC_W'(fsg_pkg::SECONDS_PER_MINUTE - 1);
   localparam logic [fsg_pkg::IVL_W-1:0] SEC_PER_MIN =
      fsg_pkg::IVL_W'(fsg_pkg::SECONDS_PER_MINUTE);
   localparam logic [fsg_pkg::FRC_W-1:0] FORCE_LOAD =
      fsg_pkg::FRC_W'(fsg_pkg::FORCE_TIMEOUT_S);
   localparam logic [fsg_pkg::MIN_W-1:0] MIN_MAX = '1;

   // ------------------------------------------------------------
   // time base and rolling window
   // ------------------------------------------------------------
   logic sec_tick;
   logic [fsg_pkg::STAMP_W-1:0] now_sec;
   logic [fsg_pkg::CNT_W-1:0] hour_count;
   logic start_pulse;

   second_tick #(
      .CYCLES(CYCLES_PER_SECOND)
   ) u_tick (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .tick_o(sec_tick),
      .now_o(now_sec)
   );

   start_history u_hist (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .push_i(start_pulse),
      .now_i(now_sec),
      .count_o(hour_count)
   );

   // ------------------------------------------------------------
   // start and stop detection
   // ------------------------------------------------------------
   fsg_pkg::motor_state_e motor_state_reg;
   fsg_pkg::motor_state_e motor_state_next;

   wire below_stop = fsg_pkg::below_pct(current_i, nominal_current_i,
                                        fsg_pkg::STOP_LEVEL_PCT);
   wire above_start = (current_i > start_current_i);

   // a start needs a low current first, so power-up with a running
   // motor is not counted as a start
   always_comb
   begin
      motor_state_next = motor_state_reg;
      if (!enable_i)
         motor_state_next = fsg_pkg::MOT_UNKNOWN;
      else
      begin
         unique case (motor_state_reg)
            fsg_pkg::MOT_UNKNOWN:
               if (below_stop)
                  motor_state_next = fsg_pkg::MOT_STOPPED;
            fsg_pkg::MOT_STOPPED:
               if (above_start)
                  motor_state_next = fsg_pkg::MOT_STARTED; // see RULE_01
            fsg_pkg::MOT_STARTED:
               if (below_stop)
                  motor_state_next = fsg_pkg::MOT_STOPPED; // see RULE_02
            default:
               motor_state_next = fsg_pkg::MOT_UNKNOWN;
         endcase
      end
   end

   assign start_pulse = enable_i && (motor_state_reg == fsg_pkg::MOT_STOPPED)
                        && above_start; // see RULE_01

   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
         motor_state_reg <= fsg_pkg::MOT_UNKNOWN;
      else
         motor_state_reg <= motor_state_next;
   end

   // ------------------------------------------------------------
   // time since the latest start
   // ------------------------------------------------------------
   logic [fsg_pkg::SEC_W-1:0] sec_in_min_reg;
   logic [fsg_pkg::MIN_W-1:0] minutes_reg;
   wire min_wrap = sec_tick && (sec_in_min_reg == LAST_SEC);

   // minutes saturate rather than wrap to a misleading small value
   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         sec_in_min_reg <= '0;
         minutes_reg <= '0;
      end
      else if (start_pulse)
      begin
         sec_in_min_reg <= '0;
         minutes_reg <= '0;
      end
      else if (sec_tick)
      begin
         sec_in_min_reg <= min_wrap ? '0 : sec_in_min_reg + 1'b1;
         if (min_wrap && minutes_reg != MIN_MAX)
            minutes_reg <= minutes_reg + 1'b1;
      end
   end

   // ------------------------------------------------------------
   // interval between consecutive starts
   // ------------------------------------------------------------
   logic [fsg_pkg::IVL_W-1:0] interval_left_reg;
   wire [fsg_pkg::IVL_W-1:0] interval_load =
      fsg_pkg::IVL_W'(min_interval_i) * SEC_PER_MIN; // see RULE_11
   wire interval_active = (interval_left_reg != '0);

   // countdown in whole seconds, so the hold is exact to one second
   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
         interval_left_reg <= '0;
      else if (start_pulse)
         interval_left_reg <= interval_load; // see RULE_05
      else if (sec_tick && interval_active)
         interval_left_reg <= interval_left_reg - 1'b1; // see RULE_06
   end

   // ------------------------------------------------------------
   // alarm and inhibit levels
   // ------------------------------------------------------------
   // a zero limit switches the hourly check off
   wire limit_on = (max_starts_i != '0);
   wire limit_hit = limit_on && (hour_count >= max_starts_i); // see RULE_10
   // alarm only while exactly one start is left; a start or the
   // window dropping an old start ends it
   wire alarm_level = (max_starts_i > 8'h01)
                      && (hour_count == max_starts_i - 1'b1); // see RULE_03
   wire inhibit_level = interval_active || limit_hit; // see RULE_07

   fsg_pkg::guard_out_s normal_out;
   fsg_pkg::guard_out_s eff_out;

   assign normal_out.alarm = enable_i && alarm_level; // see RULE_04
   assign normal_out.inhibit = enable_i && inhibit_level; // see RULE_05
   assign eff_out = force_o ? forced_out_i : normal_out;

   // ------------------------------------------------------------
   // test forcing flag
   // ------------------------------------------------------------
   logic [fsg_pkg::FRC_W-1:0] force_left_reg;
   wire force_load = button_press_i || force_set_i;
   wire force_expire = sec_tick && (force_left_reg == 9'h001);

   // a press in the same cycle as expiry keeps the flag alive
   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
         force_left_reg <= '0;
      else if (force_load)
         force_left_reg <= FORCE_LOAD;
      else if (sec_tick && force_left_reg != '0)
         force_left_reg <= force_left_reg - 1'b1; // see RULE_08
   end

   // set wins over a clear or the timeout in the same cycle
   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
         force_o <= fsg_pkg::FORCE_RESET;
      else if (force_set_i)
         force_o <= 1'b1;
      else if (force_clear_i || (force_expire && !button_press_i))
         force_o <= 1'b0; // see RULE_08
   end

   // ------------------------------------------------------------
   // outputs, events and contacts
   // ------------------------------------------------------------
   fsg_pkg::event_s event_next;
   logic [fsg_pkg::N_CONTACTS-1:0] contact_next;

   assign event_next.alarm_on = eff_out.alarm && !guard_o.alarm
                                && event_enable_i.alarm_on; // see RULE_14
   assign event_next.alarm_off = !eff_out.alarm && guard_o.alarm
                                 && event_enable_i.alarm_off; // see RULE_14
   assign event_next.inhibit_on = eff_out.inhibit && !guard_o.inhibit
                                  && event_enable_i.inhibit_on; // see RULE_14
   assign event_next.inhibit_off = !eff_out.inhibit && guard_o.inhibit
                                   && event_enable_i.inhibit_off; // see RULE_14

   // invert lets a contact work normally closed, so a dead relay
   // output still blocks closing
   genvar c;
   generate
      for (c = 0; c < fsg_pkg::N_CONTACTS; c++)
      begin : g_contact
         assign contact_next[c] =
            ((contact_map_i.alarm_sel[c] && eff_out.alarm)
             || (contact_map_i.inhibit_sel[c] && eff_out.inhibit))
            ^ contact_map_i.invert[c]; // see RULE_13
      end
   endgenerate

   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         guard_o <= fsg_pkg::GUARD_RESET;
         events_o <= fsg_pkg::EVENT_RESET;
         contacts_o <= contact_map_i.invert & '0;
      end
      else
      begin
         guard_o <= eff_out;
         events_o <= event_next;
         contacts_o <= contact_next;
      end
   end

   // ------------------------------------------------------------
   // measured and recorded values
   // ------------------------------------------------------------
   logic limit_hit_reg;
   wire trip = limit_hit && !limit_hit_reg;
   wire inhibit_rise = eff_out.inhibit && !guard_o.inhibit;

   // measured values follow the live counters one cycle late
   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         starts_last_hour_o <= '0;
         minutes_since_start_o <= '0;
         motor_started_o <= 1'b0;
         limit_hit_reg <= 1'b0;
      end
      else
      begin
         starts_last_hour_o <= hour_count; // see RULE_09
         minutes_since_start_o <= minutes_reg; // see RULE_09
         motor_started_o <= (motor_state_reg == fsg_pkg::MOT_STARTED);
         limit_hit_reg <= limit_hit;
      end
   end

   // the trip record is taken when the hourly limit first blocks
   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         record_o <= fsg_pkg::RECORD_RESET;
         start_event_count_o <= '0;
      end
      else
      begin
         if (trip)
         begin
            record_o.trip_timestamp <= rtc_time_i; // see RULE_12
            record_o.recorded_starts_per_hour <= hour_count; // see RULE_12
            record_o.recorded_time_since_start <= minutes_reg;
         end
         if (start_pulse)
            record_o.total_starts <= record_o.total_starts + 1'b1;
         if (inhibit_rise)
            start_event_count_o <= start_event_count_o + 1'b1;
      end
   end

endmodule
`default_nettype wire

// ==== src/second_tick.sv ====
`timescale 1ns/10ps
`default_nettype none
// one-second enable pulse and a free running seconds stamp
module second_tick #(
   parameter int unsigned CYCLES = fsg_pkg::CYCLES_PER_SECOND
) (
   input wire logic ref_clk_i,
   input wire logic reset_i,
   output logic tick_o,
   output logic [fsg_pkg::STAMP_W-1:0] now_o
);
   localparam int unsigned DIV_W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CYCLES - 1);

   logic [DIV_W-1:0] div_reg;
   wire wrap = (div_reg == DIV_LAST);

   // divider and stamp; stamp wraps, callers use modular age
   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         div_reg <= '0;
         tick_o <= 1'b0;
         now_o <= '0;
      end
      else
      begin
         div_reg <= wrap ? '0 : div_reg + 1'b1;
         tick_o <= wrap;
         if (wrap)
            now_o <= now_o + 1'b1;
      end
   end
endmodule
`default_nettype wire

// ==== src/start_history.sv ====
`timescale 1ns/10ps
`default_nettype none
// rolling one-hour window of start stamps; count_o = starts in last hour
module start_history (
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic push_i,
   input wire logic [fsg_pkg::STAMP_W-1:0] now_i,
   output logic [fsg_pkg::CNT_W-1:0] count_o
);
   localparam logic [fsg_pkg::STAMP_W-1:0] HOUR =
      fsg_pkg::STAMP_W'(fsg_pkg::HOUR_S);
   localparam logic [fsg_pkg::CNT_W-1:0] DEPTH =
      fsg_pkg::CNT_W'(fsg_pkg::HIST_DEPTH);

   logic [fsg_pkg::STAMP_W-1:0] stamp_mem [fsg_pkg::HIST_DEPTH];
   logic [fsg_pkg::HIST_PTR_W-1:0] head_reg;
   logic [fsg_pkg::HIST_PTR_W-1:0] tail_reg;

   // modular age is exact since entries leave well before the wrap
   wire [fsg_pkg::STAMP_W-1:0] age = now_i - stamp_mem[tail_reg];
   wire nonempty = (count_o != '0);
   wire pop = nonempty && (age >= HOUR); // see RULE_07
   // a full window drops the push; only a nonzero limit of 32 or less stops starts before that
   wire push = push_i && (count_o != DEPTH || pop);

   always_ff @(posedge ref_clk_i)
   begin
      if (push)
         stamp_mem[head_reg] <= now_i;
   end

   // pointers and occupancy, one expiry per cycle at most
   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         head_reg <= '0;
         tail_reg <= '0;
         count_o <= '0;
      end
      else
      begin
         if (push)
            head_reg <= head_reg + 1'b1;
         if (pop)
            tail_reg <= tail_reg + 1'b1;
         if (push && !pop)
            count_o <= count_o + 1'b1;
         else if (pop && !push)
            count_o <= count_o - 1'b1;
      end
   end
endmodule
`default_nettype wire

// ==== verification/motor_current_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// motor current model
// ------------------------------------------------------------
// a running motor draws seven times nominal, a stopped one five
// percent, so both thresholds are crossed with margin, not grazed
module motor_current_model (
   input wire logic run_i,
   input wire logic [fsg_pkg::CUR_W-1:0] nominal_i,
   output logic [fsg_pkg::CUR_W-1:0] current_o
);
   // same unit as the nominal current
   assign current_o = run_i ? 16'(nominal_i * 7) : 16'(nominal_i / 20);
endmodule
`default_nettype wire

// ==== verification/motor_frequent_start_guard_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// guard checker
// ------------------------------------------------------------
module motor_frequent_start_guard_sva #(
   parameter int unsigned CYCLES_PER_SECOND = 4
) (
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic enable_i,
   input wire logic [fsg_pkg::CUR_W-1:0] current_i,
   input wire logic [fsg_pkg::CUR_W-1:0] nominal_current_i,
   input wire logic [fsg_pkg::CUR_W-1:0] start_current_i,
   input wire logic [fsg_pkg::CNT_W-1:0] max_starts_i,
   input wire logic [fsg_pkg::CNT_W-1:0] min_interval_i,
   input wire logic force_set_i,
   input wire logic force_clear_i,
   input wire fsg_pkg::event_s event_enable_i,
   input wire fsg_pkg::contact_map_s contact_map_i,
   input wire fsg_pkg::guard_out_s guard_o,
   input wire logic [fsg_pkg::N_CONTACTS-1:0] contacts_o,
   input wire fsg_pkg::event_s events_o,
   input wire logic [fsg_pkg::CNT_W-1:0] starts_last_hour_o,
   input wire logic force_o,
   input wire logic motor_started_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);
   // forcing or disable lingers two edges in the guard register path
   logic h1;
   logic h2;
   wire odd = reset_i | force_o | !enable_i | h1 | h2;
   wire low = ({8'h00, current_i} * 24'h000064) <
              ({8'h00, nominal_current_i} * 24'h00000a);
   always_ff @(posedge ref_clk_i)
   begin
      h1 <= reset_i | force_o | !enable_i;
      h2 <= h1;
   end
   property p_start; $rose(motor_started_o) |->
      $past(current_i > start_current_i) && $past(enable_i); endproperty
   a_start: assert property (p_start)
      else $error("start without start current");
   // the detector state and then the status register each add an edge
   property p_stop; motor_started_o && low |-> ##2 !motor_started_o;
   endproperty
   a_stop: assert property (p_stop)
      else $error("motor not stopped at low current");
   property p_alarm; !odd && max_starts_i >= 8'h02 |->
      guard_o.alarm == (starts_last_hour_o == max_starts_i - 8'h01);
   endproperty
   a_alarm: assert property (p_alarm)
      else $error("alarm level wrong");
   property p_inhibit; $rose(motor_started_o) && min_interval_i != 8'h00
      && !odd |=> guard_o.inhibit; endproperty
   a_inhibit: assert property (p_inhibit)
      else $error("no inhibit after start");
   property p_limit; !odd && max_starts_i != 8'h00 &&
      starts_last_hour_o >= max_starts_i |-> guard_o.inhibit; endproperty
   a_limit: assert property (p_limit)
      else $error("limit reached without inhibit");
   property p_fset; force_set_i |=> force_o; endproperty
   a_fset: assert property (p_fset)
      else $error("force flag not set");
   property p_fclr; force_clear_i && !force_set_i |=> !force_o;
   endproperty
   a_fclr: assert property (p_fclr)
      else $error("force flag not cleared");
   property p_contacts; !$past(reset_i) |-> contacts_o ==
      (((contact_map_i.alarm_sel & {4{guard_o.alarm}}) |
      (contact_map_i.inhibit_sel & {4{guard_o.inhibit}})) ^
      contact_map_i.invert); endproperty
   a_contacts: assert property (p_contacts)
      else $error("contact mapping wrong");
   property p_ev_on; $rose(guard_o.inhibit) |->
      events_o.inhibit_on == event_enable_i.inhibit_on; endproperty
   a_ev_on: assert property (p_ev_on)
      else $error("inhibit event missing");
   property p_ev_pulse; events_o.inhibit_on |=> !events_o.inhibit_on;
   endproperty
   a_ev_pulse: assert property (p_ev_pulse)
      else $error("inhibit event longer than one cycle");
   property p_ev_off; events_o.alarm_off |-> $fell(guard_o.alarm);
   endproperty
   a_ev_off: assert property (p_ev_off)
      else $error("alarm off event without alarm fall");
endmodule
bind motor_frequent_start_guard motor_frequent_start_guard_sva #(
   .CYCLES_PER_SECOND(CYCLES_PER_SECOND)
) u_sva (
   .ref_clk_i, .reset_i, .enable_i, .current_i, .nominal_current_i,
   .start_current_i, .max_starts_i, .min_interval_i, .force_set_i,
   .force_clear_i, .event_enable_i, .contact_map_i, .guard_o,
   .contacts_o, .events_o, .starts_last_hour_o, .force_o,
   .motor_started_o
);
`default_nettype wire

// ==== verification/motor_frequent_start_guard_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module motor_frequent_start_guard_test;
   // a second is four cycles so an hour fits in a short run
   localparam int CPS = 4;
   logic ref_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic enable_i = 1'b1;
   logic run_motor = 1'b0;
   logic button_press_i = 1'b0;
   logic force_set_i = 1'b0;
   logic force_clear_i = 1'b0;
   logic [15:0] nominal = 16'h0064;
   fsg_pkg::guard_out_s forced_out_i = 2'h0;
   fsg_pkg::event_s event_enable_i = 4'hf;
   fsg_pkg::contact_map_s contact_map_i = 12'h128;
   logic [fsg_pkg::CUR_W-1:0] current_i;
   fsg_pkg::guard_out_s guard_o;
   logic [3:0] contacts_o;
   logic [7:0] starts_last_hour_o;
   logic [15:0] minutes_since_start_o;
   logic [15:0] start_event_count_o;
   fsg_pkg::record_s record_o;
   fsg_pkg::event_s events_o;
   logic force_o;
   logic motor_started_o;
   int failures = 0;
   int checked = 0;
   int ev_count = 0;

   always #20 ref_clk_i = ~ref_clk_i;

   // event pulses last one cycle, so each is seen at exactly one negedge
   always @(negedge ref_clk_i)
      if (events_o.inhibit_on === 1'b1)
         ev_count++;

   motor_current_model u_motor (.run_i(run_motor), .nominal_i(nominal),
      .current_o(current_i));

   motor_frequent_start_guard #(.CYCLES_PER_SECOND(CPS)) u_dut (
      .ref_clk_i(ref_clk_i), .reset_i(reset_i), .enable_i(enable_i),
      .current_i(current_i), .nominal_current_i(nominal),
      .start_current_i(16'h0258), .max_starts_i(8'h03),
      .min_interval_i(8'h01), .button_press_i(button_press_i),
      .force_set_i(force_set_i), .force_clear_i(force_clear_i),
      .forced_out_i(forced_out_i), .event_enable_i(event_enable_i),
      .contact_map_i(contact_map_i), .rtc_time_i(32'h1234abcd),
      .guard_o(guard_o), .contacts_o(contacts_o), .events_o(events_o),
      .starts_last_hour_o(starts_last_hour_o),
      .minutes_since_start_o(minutes_since_start_o),
      .start_event_count_o(start_event_count_o), .record_o(record_o),
      .force_o(force_o), .motor_started_o(motor_started_o));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic check(input logic [71:0] seen, input logic [71:0] exp);
      checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("checked=%0d failures=%0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // all waits are fixed counts, so nothing can hang
   task automatic wait_s(input int s);
      repeat (s * CPS) @(negedge ref_clk_i);
   endtask

   task automatic pulse(ref logic sig);
      sig = 1'b1;
      @(negedge ref_clk_i);
      sig = 1'b0;
   endtask

   // go and halt each take one second at this time scale
   task automatic go(input logic level);
      run_motor = level;
      repeat (4) @(negedge ref_clk_i);
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      repeat (10) @(negedge ref_clk_i);
      reset_i = 1'b0;
      check(guard_o, 2'h0);
      wait_s(1);
      go(1'b1);
      check(motor_started_o, 1'b1);
      check(guard_o, 2'h1);
      check(starts_last_hour_o, 8'h01);
      check(contacts_o, 4'ha);
      go(1'b0);
      check(motor_started_o, 1'b0);
      wait_s(56);
      check(guard_o.inhibit, 1'b1);
      wait_s(4);
      check(guard_o.inhibit, 1'b0);
      check(minutes_since_start_o, 16'h0001);
      go(1'b1);
      check(guard_o, 2'h3);
      check(contacts_o, 4'hb);
      go(1'b0);
      wait_s(60);
      check(guard_o, 2'h2);
      go(1'b1);
      check(guard_o, 2'h1);
      check(start_event_count_o, 16'h0003);
      check(record_o.trip_timestamp, 32'h1234abcd);
      check(record_o.recorded_starts_per_hour, 8'h03);
      check(record_o.total_starts, 16'h0003);
      check(record_o.recorded_time_since_start, 16'h0000);
      go(1'b0);
      wait_s(62);
      check(guard_o.inhibit, 1'b1);
      check(starts_last_hour_o, 8'h03);
      wait_s(3409);
      check(guard_o.inhibit, 1'b1);
      wait_s(8);
      check(guard_o, 2'h2);
      check(starts_last_hour_o, 8'h02);
      // forcing: a button press in mid-run must restart the timeout
      forced_out_i = 2'h1;
      pulse(force_set_i);
      repeat (2) @(negedge ref_clk_i);
      check(force_o, 1'b1);
      check(guard_o, 2'h1);
      wait_s(200);
      pulse(button_press_i);
      wait_s(297);
      check(force_o, 1'b1);
      wait_s(5);
      check(force_o, 1'b0);
      check(guard_o, 2'h0);
      pulse(force_set_i);
      pulse(force_clear_i);
      @(negedge ref_clk_i);
      check(force_o, 1'b0);
      // a disabled stage must not count a start
      enable_i = 1'b0;
      go(1'b1);
      check(starts_last_hour_o, 8'h00);
      check(guard_o, 2'h0);
      // three starts and two forced inhibits each raise one event
      check(ev_count, 5);
      give_verdict();
   end
endmodule
`default_nettype wire
